// [lpc_pkg.sv]
// shared constants of both ends
//
// Behaviour
// [R01] user pairs every power-down entry with exit
// [R02] optional clock stop in power-down
// [R03] deep sleep exit reinitialises then retrains
// [R04] external refresh disables internal generator
// [R05] each request sends one refresh burst
// [R06] acknowledge marks end of refresh burst
// [R07] request drops after acknowledge is sampled
// [R08] use external refresh so retraining still runs
// [R09] command port carries mode and special commands
// [R10] wishbone mode supports only burst of two
// [R11] address 0x1 writes base mode fields
// [R12] address 0x2 writes extended mode fields
// [R13] 0x4 to 0x20 power and deep sleep
// [R14] 0x40 to 0x100 self refresh, status
// [R15] mode value on address lines, bank selects
// [R16] load mode target and value on addr
// [R17] addr 9:8 selects base or extended
// [R18] addr 7:0 carries mode register value
// [R19] internal settings follow newly written mode
// [R20] command port should write burst of two
// [R21] power codes 0101, 1010, 1011, 1100
// [R22] burst count two to eight, default eight
// [R23] new burst only on fresh request edge
package lpc_pkg;
  localparam int CMD_W = 4;
  localparam int ADDR_W = 23;
  localparam int WB_W = 32;
  localparam int MEM_A_W = 14;
  localparam int BA_W = 2;

  localparam logic [CMD_W-1:0] CMD_NONE = 4'h0;
  localparam logic [CMD_W-1:0] CMD_PDE = 4'h5;
  localparam logic [CMD_W-1:0] CMD_LMR = 4'h6;
  localparam logic [CMD_W-1:0] CMD_SRR = 4'h7;
  localparam logic [CMD_W-1:0] CMD_SRE = 4'h8;
  localparam logic [CMD_W-1:0] CMD_SRX = 4'h9;
  localparam logic [CMD_W-1:0] CMD_PDX = 4'hA;
  localparam logic [CMD_W-1:0] CMD_DEEP_SLEEP_ENTRY_CMD = 4'hB;
  localparam logic [CMD_W-1:0] CMD_DEEP_SLEEP_EXIT_CMD = 4'hC;
  localparam logic [CMD_W-1:0] CMD_AREF = 4'hD;

  localparam logic [WB_W-1:0] CP_BASE_MODE = 32'h1;
  localparam logic [WB_W-1:0] CP_EXT_MODE = 32'h2;
  localparam logic [WB_W-1:0] CP_PDE = 32'h4;
  localparam logic [WB_W-1:0] CP_PDX = 32'h8;
  localparam logic [WB_W-1:0] CP_DEEP_SLEEP_ENTRY_CMD = 32'h10;
  localparam logic [WB_W-1:0] CP_DEEP_SLEEP_EXIT_CMD = 32'h20;
  localparam logic [WB_W-1:0] CP_SRE = 32'h40;
  localparam logic [WB_W-1:0] CP_SRX = 32'h80;
  localparam logic [WB_W-1:0] CP_SRR = 32'h100;

  localparam int SEL_HI = 9;
  localparam int SEL_LO = 8;
  localparam int VAL_HI = 7;
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam logic [BA_W-1:0] BA_BASE = 2'h0;
  localparam logic [BA_W-1:0] BA_EXT = 2'h2;

  localparam int BL_LO = 0;
  localparam int BL_HI = 2;
  localparam int BT_BIT = 3;
  localparam int CL_LO = 4;
  localparam int CL_HI = 6;
  localparam int PAR_LO = 0;
  localparam int PAR_HI = 2;
  localparam int TCR_LO = 3;
  localparam int TCR_HI = 4;
  localparam int DS_LO = 5;
  localparam int DS_HI = 7;

  localparam logic [2:0] BURST_OF_TWO = 3'h1;
  localparam logic [2:0] BL_RESET = 3'h3;
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam int REF_BURST_MIN = 2;
  localparam int REF_BURST_DEF = 8;
  localparam int INIT_CYCLES_DEF = 200;
  localparam int TRAIN_CYCLES_DEF = 64;
endpackage : lpc_pkg

// [lpc_if.sv]
// link between the user end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface lpc_if;
  logic cmd_valid;
  logic cmd_rdy;
  logic [lpc_pkg::CMD_W-1:0] cmd;
  logic [lpc_pkg::ADDR_W-1:0] addr;
  logic ext_ref_req;
  logic ext_ref_ack;
  logic cyc;
  logic stb;
  logic we;
  logic [lpc_pkg::WB_W-1:0] command_port_address;
  logic [lpc_pkg::WB_W-1:0] command_port_write_data;
  logic [lpc_pkg::WB_W-1:0] dat_o;
  logic ack;

  modport dev (
    input cmd_valid, cmd, addr, ext_ref_req, cyc, stb, we,
    input command_port_address, command_port_write_data,
    output cmd_rdy, ext_ref_ack, dat_o, ack
  );
  modport host (
    output cmd_valid, cmd, addr, ext_ref_req, cyc, stb, we,
    output command_port_address, command_port_write_data,
    input cmd_rdy, ext_ref_ack, dat_o, ack
  );
endinterface : lpc_if
`default_nettype wire

// [lpc_dev.sv]
// controller end: power states, refresh and mode loads
`timescale 1ns/1ps
`default_nettype none
module lpc_dev #(
  parameter bit EXT_REF = 1'b1,
  parameter bit WB_EN = 1'b1,
  parameter bit MEM_CLK_OFF = 1'b1,
  parameter int REF_BURST = lpc_pkg::REF_BURST_DEF,
  parameter int INIT_CYCLES = lpc_pkg::INIT_CYCLES_DEF,
  parameter int TRAIN_CYCLES = lpc_pkg::TRAIN_CYCLES_DEF
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  lpc_if.dev link,
  output logic mem_cmd_valid_out,
  output logic [lpc_pkg::CMD_W-1:0] mem_cmd_out,
  output logic [lpc_pkg::BA_W-1:0] memory_bank_select_out,
  output logic [lpc_pkg::MEM_A_W-1:0] memory_address_bus_out,
  output logic mem_clk_en_out,
  output logic mem_cke_out,
  output logic int_refresh_en_out,
  output logic init_busy_out,
  output logic train_busy_out,
  output logic [2:0] burst_len_out,
  output logic burst_type_out,
  output logic [2:0] cas_latency_out,
  output logic [2:0] partial_array_refresh_out,
  output logic [1:0] temp_comp_refresh_out,
  output logic [2:0] drive_strength_out
);
  typedef enum logic [2:0] {
    LPC_IDLE = 3'h0,
    LPC_PDOWN = 3'h1,
    LPC_DEEP = 3'h2,
    LPC_INIT = 3'h3,
    LPC_TRAIN = 3'h4,
    LPC_SELF = 3'h5,
    LPC_REF = 3'h6
  } lpc_state_t;

  localparam int CNT_W_L = 16;
  // out-of-range refresh burst counts are clamped
  localparam int REF_N = (REF_BURST < lpc_pkg::REF_BURST_MIN) ? lpc_pkg::REF_BURST_MIN :
                         (REF_BURST > lpc_pkg::REF_BURST_DEF) ? lpc_pkg::REF_BURST_DEF :
                         REF_BURST; // R22
  localparam logic [CNT_W_L-1:0] REF_LAST = CNT_W_L'(REF_N - 1);
  localparam logic [CNT_W_L-1:0] INIT_LAST = CNT_W_L'(INIT_CYCLES - 1);
  localparam logic [CNT_W_L-1:0] TRAIN_LAST = CNT_W_L'(TRAIN_CYCLES - 1);

  lpc_state_t state_reg;
  lpc_state_t state_next;
  logic [CNT_W_L-1:0] cnt_reg;
  logic req_seen_reg;
  logic ack_reg;
  logic wb_ack_reg;
  logic [2:0] bl_reg;
  logic bt_reg;
  logic [2:0] cl_reg;
  logic [2:0] par_reg;
  logic [1:0] tcr_reg;
  logic [2:0] ds_reg;

  logic cmd_take;
  logic wb_req;
  logic wb_take;
  logic op_valid;
  logic [lpc_pkg::CMD_W-1:0] op_code;
  logic mode_wr;
  logic mode_ext;
  logic [7:0] mode_val;
  logic ref_start;

  // unmapped addresses give no command
  function automatic logic [lpc_pkg::CMD_W-1:0] cp_decode(input logic [lpc_pkg::WB_W-1:0] a);
    unique case (a)
      lpc_pkg::CP_BASE_MODE, lpc_pkg::CP_EXT_MODE: cp_decode = lpc_pkg::CMD_LMR; // R09
      lpc_pkg::CP_PDE: cp_decode = lpc_pkg::CMD_PDE; // R13
      lpc_pkg::CP_PDX: cp_decode = lpc_pkg::CMD_PDX; // R13
      lpc_pkg::CP_DEEP_SLEEP_ENTRY_CMD: cp_decode = lpc_pkg::CMD_DEEP_SLEEP_ENTRY_CMD; // R13
      lpc_pkg::CP_DEEP_SLEEP_EXIT_CMD: cp_decode = lpc_pkg::CMD_DEEP_SLEEP_EXIT_CMD; // R13
      lpc_pkg::CP_SRE: cp_decode = lpc_pkg::CMD_SRE; // R14
      lpc_pkg::CP_SRX: cp_decode = lpc_pkg::CMD_SRX; // R14
      lpc_pkg::CP_SRR: cp_decode = lpc_pkg::CMD_SRR; // R14
      default: cp_decode = lpc_pkg::CMD_NONE;
    endcase
  endfunction : cp_decode

  // legal only in its own state
  function automatic logic legal(input lpc_state_t s, input logic [lpc_pkg::CMD_W-1:0] c);
    unique case (c)
      lpc_pkg::CMD_PDX: legal = (s == LPC_PDOWN);
      lpc_pkg::CMD_DEEP_SLEEP_EXIT_CMD: legal = (s == LPC_DEEP);
      lpc_pkg::CMD_SRX: legal = (s == LPC_SELF);
      default: legal = (s == LPC_IDLE);
    endcase
  endfunction : legal

  // command port wins over the generic port
  assign wb_req = WB_EN && link.cyc && link.stb && !wb_ack_reg;
  assign link.cmd_rdy = !wb_req && (state_reg == LPC_IDLE || state_reg == LPC_PDOWN ||
                        state_reg == LPC_DEEP || state_reg == LPC_SELF);
  assign cmd_take = link.cmd_valid && link.cmd_rdy;
  // every write is acked; illegal ones dropped
  assign wb_take = wb_req && link.we;
  assign ref_start = EXT_REF && link.ext_ref_req && !req_seen_reg && !ack_reg &&
                     state_reg == LPC_IDLE && !cmd_take && !wb_take; // R23

  always_comb begin
    op_code = lpc_pkg::CMD_NONE;
    mode_wr = 1'b0;
    mode_ext = 1'b0;
    mode_val = 8'h00;
    if (wb_take) begin
      op_code = cp_decode(link.command_port_address);
      mode_wr = (op_code == lpc_pkg::CMD_LMR);
      mode_ext = (link.command_port_address == lpc_pkg::CP_EXT_MODE); // R12
      mode_val = link.command_port_write_data[lpc_pkg::VAL_HI:0]; // R11
    end else if (cmd_take) begin
      op_code = link.cmd;
      mode_wr = (link.cmd == lpc_pkg::CMD_LMR) &&
                (link.addr[lpc_pkg::SEL_HI:lpc_pkg::SEL_LO] == lpc_pkg::SEL_BASE ||
                 link.addr[lpc_pkg::SEL_HI:lpc_pkg::SEL_LO] == lpc_pkg::SEL_EXT); // R17
      mode_ext = (link.addr[lpc_pkg::SEL_HI:lpc_pkg::SEL_LO] == lpc_pkg::SEL_EXT); // R17
      mode_val = link.addr[lpc_pkg::VAL_HI:0]; // R16 R18
    end
  end
  assign op_valid = (op_code != lpc_pkg::CMD_NONE) && legal(state_reg, op_code);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LPC_IDLE: begin
        if (ref_start) begin
          state_next = LPC_REF;
        end else if (op_valid) begin
          unique case (op_code)
            lpc_pkg::CMD_PDE: state_next = LPC_PDOWN;
            lpc_pkg::CMD_DEEP_SLEEP_ENTRY_CMD: state_next = LPC_DEEP;
            lpc_pkg::CMD_SRE: state_next = LPC_SELF;
            default: state_next = LPC_IDLE;
          endcase
        end
      end
      LPC_PDOWN: if (op_valid) state_next = LPC_IDLE;
      LPC_SELF: if (op_valid) state_next = LPC_IDLE;
      LPC_DEEP: if (op_valid) state_next = LPC_INIT; // R03
      LPC_INIT: if (cnt_reg == INIT_LAST) state_next = LPC_TRAIN; // R03
      LPC_TRAIN: if (cnt_reg == TRAIN_LAST) state_next = LPC_IDLE; // R03
      LPC_REF: if (cnt_reg == REF_LAST) state_next = LPC_IDLE; // R05
      default: state_next = LPC_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= LPC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || state_next != state_reg) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W_L'(1);
    end
  end

  // ack holds until req is low, so a held req never retriggers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      if (state_reg == LPC_REF && cnt_reg == REF_LAST) begin
        ack_reg <= 1'b1; // R06
      end else if (!link.ext_ref_req) begin
        ack_reg <= 1'b0; // R23
      end
      if (ref_start) begin
        req_seen_reg <= 1'b1;
      end else if (!link.ext_ref_req) begin
        req_seen_reg <= 1'b0;
      end
    end
  end
  assign link.ext_ref_ack = ack_reg;
  assign int_refresh_en_out = !EXT_REF; // R04

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wb_ack_reg <= 1'b0;
    end else begin
      wb_ack_reg <= wb_req;
    end
  end
  assign link.ack = wb_ack_reg;
  assign link.dat_o = '0;

  // mode value rides on the address lines
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mem_cmd_valid_out <= 1'b0;
      mem_cmd_out <= lpc_pkg::CMD_NONE;
      memory_bank_select_out <= '0;
      memory_address_bus_out <= '0;
    end else begin
      mem_cmd_valid_out <= 1'b0;
      mem_cmd_out <= lpc_pkg::CMD_NONE;
      if (state_reg == LPC_REF) begin
        mem_cmd_valid_out <= 1'b1; // R05
        mem_cmd_out <= lpc_pkg::CMD_AREF;
      end else if (op_valid && !ref_start) begin
        mem_cmd_valid_out <= (op_code != lpc_pkg::CMD_LMR) || mode_wr;
        mem_cmd_out <= op_code; // R21
        if (mode_wr) begin
          memory_bank_select_out <= mode_ext ? lpc_pkg::BA_EXT : lpc_pkg::BA_BASE; // R15
          memory_address_bus_out <= lpc_pkg::MEM_A_W'(mode_val); // R15
        end
      end
    end
  end

  // settings follow mode writes
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bl_reg <= WB_EN ? lpc_pkg::BURST_OF_TWO : lpc_pkg::BL_RESET;
      bt_reg <= 1'b0;
      cl_reg <= lpc_pkg::CL_RESET;
      par_reg <= '0;
      tcr_reg <= '0;
      ds_reg <= '0;
    end else if (op_valid && mode_wr && !ref_start) begin
      if (mode_ext) begin
        par_reg <= mode_val[lpc_pkg::PAR_HI:lpc_pkg::PAR_LO]; // R19
        tcr_reg <= mode_val[lpc_pkg::TCR_HI:lpc_pkg::TCR_LO];
        ds_reg <= mode_val[lpc_pkg::DS_HI:lpc_pkg::DS_LO];
      end else begin
        // only burst of two with the bus on
        bl_reg <= WB_EN ? lpc_pkg::BURST_OF_TWO : mode_val[lpc_pkg::BL_HI:lpc_pkg::BL_LO]; // R10 R19
        bt_reg <= mode_val[lpc_pkg::BT_BIT];
        cl_reg <= mode_val[lpc_pkg::CL_HI:lpc_pkg::CL_LO];
      end
    end
  end
  assign burst_len_out = bl_reg;
  assign burst_type_out = bt_reg;
  assign cas_latency_out = cl_reg;
  assign partial_array_refresh_out = par_reg;
  assign temp_comp_refresh_out = tcr_reg;
  assign drive_strength_out = ds_reg;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mem_clk_en_out <= 1'b1;
      mem_cke_out <= 1'b1;
    end else begin
      mem_cke_out <= !(state_next == LPC_PDOWN || state_next == LPC_DEEP ||
                       state_next == LPC_SELF);
      mem_clk_en_out <= !(MEM_CLK_OFF && (state_next == LPC_PDOWN ||
                          state_next == LPC_DEEP || state_next == LPC_SELF)); // R02
    end
  end
  assign init_busy_out = (state_reg == LPC_INIT);
  assign train_busy_out = (state_reg == LPC_TRAIN);
endmodule : lpc_dev
`default_nettype wire

// [lpc_host.sv]
// user end: commands, command port writes, refresh
`timescale 1ns/1ps
`default_nettype none
module lpc_host (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  lpc_if.host link,
  input wire logic cmd_go_in,
  input wire logic [lpc_pkg::CMD_W-1:0] cmd_code_in,
  input wire logic [lpc_pkg::ADDR_W-1:0] cmd_addr_in,
  input wire logic cp_go_in,
  input wire logic [lpc_pkg::WB_W-1:0] cp_addr_in,
  input wire logic [lpc_pkg::WB_W-1:0] cp_data_in,
  input wire logic ref_go_in,
  output logic cmd_busy_out,
  output logic cp_busy_out,
  output logic ref_busy_out,
  output logic refused_out,
  output logic ref_done_out
);
  logic cmd_pend_reg;
  logic cp_pend_reg;
  logic ref_reg;
  logic in_pd_reg;
  logic pd_entry;
  logic pd_exit;
  logic bad;

  // refuse what would break entry/exit pairing
  assign pd_entry = (cmd_go_in && cmd_code_in == lpc_pkg::CMD_PDE) ||
                    (cp_go_in && cp_addr_in == lpc_pkg::CP_PDE);
  assign pd_exit = (cmd_go_in && cmd_code_in == lpc_pkg::CMD_PDX) ||
                   (cp_go_in && cp_addr_in == lpc_pkg::CP_PDX);
  assign bad = (pd_entry && in_pd_reg) || (pd_exit && !in_pd_reg); // R01

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      in_pd_reg <= 1'b0;
      refused_out <= 1'b0;
    end else begin
      refused_out <= bad || (cmd_go_in && cmd_pend_reg) || (cp_go_in && cp_pend_reg);
      if (pd_entry && !bad) begin
        in_pd_reg <= 1'b1; // R01
      end else if (pd_exit && !bad) begin
        in_pd_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cmd_pend_reg <= 1'b0;
      link.cmd <= lpc_pkg::CMD_NONE;
      link.addr <= '0;
    end else if (!cmd_pend_reg && cmd_go_in && !bad) begin
      cmd_pend_reg <= 1'b1;
      link.cmd <= cmd_code_in;
      link.addr <= cmd_addr_in; // R16
    end else if (link.cmd_rdy) begin
      cmd_pend_reg <= 1'b0;
    end
  end
  assign link.cmd_valid = cmd_pend_reg;

  // burst field forced to two, the only supported length
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cp_pend_reg <= 1'b0;
      link.command_port_address <= '0;
      link.command_port_write_data <= '0;
    end else if (!cp_pend_reg && cp_go_in && !bad) begin
      cp_pend_reg <= 1'b1;
      link.command_port_address <= cp_addr_in;
      link.command_port_write_data <= cp_data_in;
      if (cp_addr_in == lpc_pkg::CP_BASE_MODE) begin
        link.command_port_write_data[lpc_pkg::BL_HI:lpc_pkg::BL_LO] <= lpc_pkg::BURST_OF_TWO; // R20
      end
    end else if (link.ack) begin
      cp_pend_reg <= 1'b0;
    end
  end
  assign link.cyc = cp_pend_reg;
  assign link.stb = cp_pend_reg;
  assign link.we = cp_pend_reg;

  // req dropped the cycle after ack is sampled
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ref_reg <= 1'b0;
      ref_done_out <= 1'b0;
    end else begin
      ref_done_out <= ref_reg && link.ext_ref_ack;
      if (ref_reg && link.ext_ref_ack) begin
        ref_reg <= 1'b0; // R07
      end else if (ref_go_in && !link.ext_ref_ack) begin
        ref_reg <= 1'b1; // R08
      end
    end
  end
  assign link.ext_ref_req = ref_reg;

  assign cmd_busy_out = cmd_pend_reg;
  assign cp_busy_out = cp_pend_reg;
  assign ref_busy_out = ref_reg;
endmodule : lpc_host
`default_nettype wire

// [lpc_assertions.sv]
// link and memory command checks
`timescale 1ns/1ps
`default_nettype none
module lpc_assertions #(
  parameter int REF_BURST = lpc_pkg::REF_BURST_DEF
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic cmd_valid,
  input wire logic cmd_rdy,
  input wire logic [lpc_pkg::CMD_W-1:0] cmd,
  input wire logic [lpc_pkg::ADDR_W-1:0] addr,
  input wire logic ext_ref_req,
  input wire logic ext_ref_ack,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [lpc_pkg::WB_W-1:0] command_port_address,
  input wire logic ack,
  input wire logic mem_cmd_valid_out,
  input wire logic [lpc_pkg::CMD_W-1:0] mem_cmd_out,
  input wire logic [lpc_pkg::BA_W-1:0] memory_bank_select_out,
  input wire logic [lpc_pkg::MEM_A_W-1:0] memory_address_bus_out,
  input wire logic mem_clk_en_out,
  input wire logic mem_cke_out,
  input wire logic init_busy_out,
  input wire logic train_busy_out
);
  // refresh pulses in a row
  logic [3:0] aref_run_reg;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      aref_run_reg <= 4'h0;
    end else if (mem_cmd_valid_out && mem_cmd_out == lpc_pkg::CMD_AREF) begin
      aref_run_reg <= aref_run_reg + 4'h1;
    end else begin
      aref_run_reg <= 4'h0;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

  property p_cp_answer;
    cyc && stb && we && !ack && !$past(ack) |=> ack;
  endproperty
  a_cp_answer: assert property (p_cp_answer) else $error("no ack");

  // idle only; elsewhere dropping is legal
  property p_cp_pde;
    cyc && stb && we && !ack && !$past(ack) && mem_cke_out && !ext_ref_req && !init_busy_out
      && !train_busy_out && command_port_address == lpc_pkg::CP_PDE
      |=> mem_cmd_valid_out && mem_cmd_out == lpc_pkg::CMD_PDE;
  endproperty
  a_cp_pde: assert property (p_cp_pde) else $error("pde missing");

  property p_mode_load;
    cmd_valid && cmd_rdy && mem_cke_out && cmd == lpc_pkg::CMD_LMR && addr[8] == 1'b0
      |=> mem_cmd_valid_out && mem_cmd_out == lpc_pkg::CMD_LMR
      && memory_bank_select_out == $past(addr[9:8])
      && memory_address_bus_out == {6'h00, $past(addr[7:0])};
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("bad mode load");

  property p_pd_clock;
    mem_cmd_valid_out && mem_cmd_out == lpc_pkg::CMD_PDE |-> !mem_clk_en_out && !mem_cke_out;
  endproperty
  a_pd_clock: assert property (p_pd_clock) else $error("clock on in pde");

  property p_ref_count;
    $rose(ext_ref_ack) |-> mem_cmd_valid_out && aref_run_reg == 4'(REF_BURST - 1);
  endproperty
  a_ref_count: assert property (p_ref_count) else $error("bad burst");

  property p_ack_release;
    ext_ref_ack |=> ext_ref_ack == $past(ext_ref_req);
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("bad ack");

  property p_deep_init;
    mem_cmd_valid_out && mem_cmd_out == lpc_pkg::CMD_DEEP_SLEEP_EXIT_CMD |-> init_busy_out && !cmd_rdy;
  endproperty
  a_deep_init: assert property (p_deep_init) else $error("no init");

  property p_init_train;
    $fell(init_busy_out) |-> train_busy_out && !cmd_rdy;
  endproperty
  a_init_train: assert property (p_init_train) else $error("no training");
endmodule : lpc_assertions
`default_nettype wire

// [test_lpddr_power_refresh_mode_ctrl.sv]
// bench for both ends
`timescale 1ns/1ps
`default_nettype none
module test_lpddr_power_refresh_mode_ctrl;
  logic clock_in, sys_rst_in, cmd_go, cp_go, ref_go;
  logic [3:0] cmd_code, mc, bad_mc;
  logic [22:0] cmd_addr;
  logic [31:0] cp_addr, cp_data;
  logic cmd_busy, cp_busy, ref_busy, refused, ref_done;
  logic mcv, clk_en, cke, int_ref, init_busy, train_busy, bt, bad_mcv;
  logic [1:0] ba, tcr;
  logic [13:0] ma;
  logic [2:0] bl, cl, par, ds;
  int mismatches, n_tests, n_refused, n_done, n_bad_aref;
  bit saw_init, saw_train;
  logic [3:0] seen_q[$];
  logic [31:0] cp_tab[7] = '{32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h80, 32'h100};
  logic [3:0] code_tab[7] = '{4'h5, 4'hA, 4'hB, 4'hC, 4'h8, 4'h9, 4'h7};

  lpc_if link();
  lpc_if bad_link();
  lpc_dev #(.INIT_CYCLES(4), .TRAIN_CYCLES(4)) lpc_dev_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .link(link), .mem_cmd_valid_out(mcv),
    .mem_cmd_out(mc), .memory_bank_select_out(ba), .memory_address_bus_out(ma),
    .mem_clk_en_out(clk_en), .mem_cke_out(cke), .int_refresh_en_out(int_ref),
    .init_busy_out(init_busy), .train_busy_out(train_busy), .burst_len_out(bl),
    .burst_type_out(bt), .cas_latency_out(cl), .partial_array_refresh_out(par),
    .temp_comp_refresh_out(tcr), .drive_strength_out(ds));
  lpc_host lpc_host_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .link(link), .cmd_go_in(cmd_go),
    .cmd_code_in(cmd_code), .cmd_addr_in(cmd_addr), .cp_go_in(cp_go), .cp_addr_in(cp_addr),
    .cp_data_in(cp_data), .ref_go_in(ref_go), .cmd_busy_out(cmd_busy), .cp_busy_out(cp_busy),
    .ref_busy_out(ref_busy), .refused_out(refused), .ref_done_out(ref_done));
  // shortest burst, request held too long
  lpc_dev #(.REF_BURST(2), .INIT_CYCLES(4), .TRAIN_CYCLES(4)) lpc_dev_i2 (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .link(bad_link), .mem_cmd_valid_out(bad_mcv),
    .mem_cmd_out(bad_mc), .memory_bank_select_out(), .memory_address_bus_out(),
    .mem_clk_en_out(), .mem_cke_out(), .int_refresh_en_out(), .init_busy_out(),
    .train_busy_out(), .burst_len_out(), .burst_type_out(), .cas_latency_out(),
    .partial_array_refresh_out(), .temp_comp_refresh_out(), .drive_strength_out());
  lpc_assertions #(.REF_BURST(8)) lpc_assertions_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .cmd_valid(link.cmd_valid),
    .cmd_rdy(link.cmd_rdy), .cmd(link.cmd), .addr(link.addr), .ext_ref_req(link.ext_ref_req),
    .ext_ref_ack(link.ext_ref_ack), .cyc(link.cyc), .stb(link.stb), .we(link.we),
    .command_port_address(link.command_port_address), .ack(link.ack),
    .mem_cmd_valid_out(mcv), .mem_cmd_out(mc), .memory_bank_select_out(ba),
    .memory_address_bus_out(ma), .mem_clk_en_out(clk_en), .mem_cke_out(cke),
    .init_busy_out(init_busy), .train_busy_out(train_busy));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // sample away from the launch edge
  always @(negedge clock_in) begin
    if (mcv === 1'b1) seen_q.push_back(mc);
    if (init_busy === 1'b1) saw_init = 1'b1;
    if (train_busy === 1'b1 && saw_init) saw_train = 1'b1;
    if (refused === 1'b1) n_refused++;
    if (ref_done === 1'b1) n_done++;
    if (bad_mcv === 1'b1 && bad_mc === lpc_pkg::CMD_AREF) n_bad_aref++;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wait_idle();
    int i;
    for (i = 0; i < 80; i++) begin
      if (!cmd_busy && !cp_busy && !ref_busy && link.cmd_rdy) break;
      @(negedge clock_in);
    end
    check("idle", 32'h0, 32'(i == 80));
  endtask : wait_idle

  task automatic go(input bit cp, input logic [31:0] a, input logic [31:0] d);
    wait_idle();
    {cp_addr, cp_data, cmd_code, cmd_addr} = {a, d, a[3:0], d[22:0]};
    {cp_go, cmd_go} = {cp, !cp};
    @(negedge clock_in);
    {cp_go, cmd_go} = 2'h0;
  endtask : go

  task automatic expect_cmd(input logic [3:0] code);
    int i;
    logic [31:0] got;
    got = 32'hFFFFFFFF;
    for (i = 0; i < 40 && seen_q.size() == 0; i++) @(negedge clock_in);
    if (seen_q.size() != 0) got = 32'(seen_q.pop_front());
    check("mem_cmd", 32'(code), got);
    repeat (2) @(negedge clock_in);
  endtask : expect_cmd

  task automatic no_cmd();
    repeat (6) @(negedge clock_in);
    check("no_cmd", 32'h0, 32'(seen_q.size()));
  endtask : no_cmd

  task automatic t_reset();
    check("cmd_rdy", 32'h1, 32'(link.cmd_rdy));
    check("burst_len", 32'h1, 32'(bl));
    check("clk_en", 32'h1, 32'(clk_en));
    check("int_ref", 32'h0, 32'(int_ref));
  endtask : t_reset

  task automatic t_modes();
    go(1'b0, 32'(lpc_pkg::CMD_LMR), 32'h3A);
    expect_cmd(lpc_pkg::CMD_LMR);
    check("bank", 32'h0, 32'(ba));
    check("maddr", 32'h3A, 32'(ma));
    check("btype", 32'h1, 32'(bt));
    check("burst_len", 32'h1, 32'(bl));
    go(1'b0, 32'(lpc_pkg::CMD_LMR), 32'h12B6);
    expect_cmd(lpc_pkg::CMD_LMR);
    check("bank", 32'h2, 32'(ba));
    check("maddr", 32'hB6, 32'(ma));
    check("par", 32'h6, 32'(par));
    check("tcr", 32'h2, 32'(tcr));
    check("ds", 32'h5, 32'(ds));
    go(1'b0, 32'(lpc_pkg::CMD_LMR), 32'h155);
    no_cmd();
    go(1'b1, lpc_pkg::CP_BASE_MODE, 32'h0000002C);
    expect_cmd(lpc_pkg::CMD_LMR);
    check("bank", 32'h0, 32'(ba));
    check("maddr", 32'h29, 32'(ma));
    check("cas", 32'h2, 32'(cl));
    go(1'b1, lpc_pkg::CP_EXT_MODE, 32'hFFFFFF4D);
    expect_cmd(lpc_pkg::CMD_LMR);
    check("bank", 32'h2, 32'(ba));
    check("maddr", 32'h4D, 32'(ma));
    check("ext", 32'h4D, 32'({ds, tcr, par}));
    go(1'b1, 32'h00000003, 32'h0);
    no_cmd();
  endtask : t_modes

  task automatic t_power(input bit via_cp);
    int i;
    for (i = 0; i < 7; i++) begin
      saw_init = 1'b0;
      saw_train = 1'b0;
      go(via_cp, via_cp ? cp_tab[i] : 32'(code_tab[i]), 32'hFFFFFFFF);
      expect_cmd(code_tab[i]);
      if (i == 0) check("clk_off", 32'h0, 32'({clk_en, cke}));
      if (i == 1) check("clk_on", 32'h3, 32'({clk_en, cke}));
      if (i == 3) begin
        wait_idle();
        check("reinit", 32'h3, 32'({saw_init, saw_train}));
      end
    end
  endtask : t_power

  task automatic t_refresh();
    int i;
    n_refused = 0;
    go(1'b0, 32'(lpc_pkg::CMD_PDX), 32'h0);
    no_cmd();
    check("refused", 32'h1, 32'(n_refused));
    n_done = 0;
    wait_idle();
    ref_go = 1'b1;
    @(negedge clock_in);
    ref_go = 1'b0;
    for (i = 0; i < lpc_pkg::REF_BURST_DEF; i++) expect_cmd(lpc_pkg::CMD_AREF);
    for (i = 0; i < 20 && n_done == 0; i++) @(negedge clock_in);
    check("ref_done", 32'h1, 32'(n_done));
    for (i = 0; i < 10 && link.ext_ref_ack !== 1'b0; i++) @(negedge clock_in);
    check("ack_low", 32'h0, 32'(link.ext_ref_ack));
    no_cmd();
  endtask : t_refresh

  task automatic t_bad_req();
    n_bad_aref = 0;
    {bad_link.cyc, bad_link.ext_ref_req} = 2'h3;
    repeat (30) @(negedge clock_in);
    check("burst", 32'h2, 32'(n_bad_aref));
    check("ack_held", 32'h1, 32'(bad_link.ext_ref_ack));
    bad_link.ext_ref_req = 1'b0;
    repeat (3) @(negedge clock_in);
    check("ack_drop", 32'h0, 32'(bad_link.ext_ref_ack));
    bad_link.ext_ref_req = 1'b1;
    repeat (30) @(negedge clock_in);
    check("burst_again", 32'h4, 32'(n_bad_aref));
    {bad_link.cyc, bad_link.ext_ref_req} = 2'h0;
  endtask : t_bad_req

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    test_done();
  end

  initial begin
    sys_rst_in = 1'b1;
    {cmd_go, cp_go, ref_go, cmd_code, cmd_addr, cp_addr, cp_data} = '0;
    {bad_link.cmd_valid, bad_link.cmd, bad_link.addr, bad_link.ext_ref_req} = '0;
    {bad_link.cyc, bad_link.stb, bad_link.we} = '0;
    {bad_link.command_port_address, bad_link.command_port_write_data} = '0;
    repeat (10) @(posedge clock_in);
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    @(negedge clock_in);
    t_reset();
    t_modes();
    t_power(1'b1);
    t_power(1'b0);
    t_refresh();
    t_bad_req();
    test_done();
  end
endmodule : test_lpddr_power_refresh_mode_ctrl
`default_nettype wire
